// [rtl/clock_divide_delay_sync.sv]
// clock divide, digital delay and output synchronisation for two banks
// What this block does
// - driven strap pin selects fixed pin mappings
// - bank a/b inputs, bypassable 2-7 divider
// - groups 1-3 divide 1-15, group4 1-2047
// - group4 delay spans 4.5 to 522 periods
// - delay is count, minus half when set
// - max relative delay 522 or 523 periods
// - delay count applied only at included sync
// - half-step change acts immediately
// - delay step is half distribution period
// - sync aligns groups; excluded groups untouched
// - selected outputs held low during sync
// - on release selected groups 1-3 rise together
// - polarity bit reverses sync pin sense
// - group4 rises after delay plus 5/6
// - toggling polarity bit asserts a sync
`timescale 1ns/1ps
`include "clkdiv_regs.svh"

module clock_divide_delay_sync (
    // clock and reset
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    // ahb-lite slave
    input  wire clkdiv_pkg::ahb_req_s ahb_req,
    input  wire logic [31:0]          hwdata,
    output logic [31:0]               hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    // pins
    input  wire logic                 bank_a_clock_input,
    input  wire logic                 bank_b_clock_input,
    input  wire logic                 sync_pin,
    input  wire logic                 cfg_sel_level,
    input  wire logic                 cfg_sel_driven,
    // clock outputs
    output logic [2:0]                group_clock_out,
    output logic                      group4_output_a,
    output logic                      group4_output_b
);
    import clkdiv_pkg::*;

    // ---------------------------------------------------------------
    // pin resampling
    // ---------------------------------------------------------------
    logic [4:0]  pin_raw;
    logic [4:0]  pin_s1_r;
    logic [4:0]  pin_s2_r;
    logic [4:0]  pin_s3_r;
    logic [4:0]  pin_f_r;

    assign pin_raw = {cfg_sel_driven, cfg_sel_level, sync_pin,
                      bank_b_clock_input, bank_a_clock_input};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_s1_r <= 5'h00;
            pin_s2_r <= 5'h00;
            pin_s3_r <= 5'h00;
        end else begin
            pin_s1_r <= pin_raw;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_f_r <= 5'h00;
        end else begin
            pin_f_r <= (pin_s2_r & ~(pin_s2_r ^ pin_s3_r)) | (pin_f_r & (pin_s2_r ^ pin_s3_r));
        end
    end

    // ---------------------------------------------------------------
    // register file
    // ---------------------------------------------------------------
    cfg_s        cfg_r;
    logic        wr_pend_r;
    logic [7:0]  wr_addr_r;
    logic        addr_ok;
    logic [5:0]  sw_sync_cnt_r;
    logic [1:0]  sync_r;
    logic [9:0]  applied_dly_r;

    assign addr_ok = ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end else begin
            wr_pend_r <= addr_ok & ahb_req.hwrite;
            wr_addr_r <= ahb_req.haddr;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_r.in_en   <= 2'b00;
            cfg_r.in_div  <= {`RST_IN_DIV, `RST_IN_DIV};
            cfg_r.grp_div <= {`RST_GRP_DIV, `RST_GRP_DIV, `RST_GRP_DIV};
            cfg_r.g4_div  <= `RST_G4_DIV;
            cfg_r.excl    <= 4'h0;
            cfg_r.inv     <= 1'b0;
            cfg_r.dly     <= `RST_DLY;
            cfg_r.hs      <= 1'b0;
        end else if (wr_pend_r) begin
            unique case (wr_addr_r)
                `REG_INPUT_CTRL: begin
                    cfg_r.in_en     <= hwdata[`F_IN_EN_B:`F_IN_EN_A];
                    cfg_r.in_div[0] <= hwdata[`F_IN_DIV_A_LO +: 3];
                    cfg_r.in_div[1] <= hwdata[`F_IN_DIV_B_LO +: 3];
                    cfg_r.excl      <= hwdata[`F_EXCL_LO +: 4];
                    cfg_r.inv       <= hwdata[`F_POL_INV];
                end
                `REG_GROUP_DIV: begin
                    cfg_r.grp_div <= hwdata[11:0];
                    cfg_r.g4_div  <= hwdata[`F_G4_DIV_LO +: 11];
                end
                `REG_DELAY_CTRL: begin
                    cfg_r.dly <= hwdata[`F_DLY_LO +: 10];
                    cfg_r.hs  <= hwdata[`F_HS];
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sw_sync_cnt_r <= 6'h00;
        end else if (wr_pend_r && wr_addr_r == `REG_INPUT_CTRL
                     && hwdata[`F_POL_INV] != cfg_r.inv) begin
            sw_sync_cnt_r <= `SW_SYNC_CYCLES;
        end else if (sw_sync_cnt_r != 6'h00) begin
            sw_sync_cnt_r <= sw_sync_cnt_r - 6'h01;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_ok && !ahb_req.hwrite) begin
            unique case (ahb_req.haddr)
                `REG_INPUT_CTRL: hrdata <= {15'h0000, cfg_r.inv, cfg_r.excl, 1'b0,
                                            cfg_r.in_div[1], 1'b0, cfg_r.in_div[0],
                                            2'b00, cfg_r.in_en};
                `REG_GROUP_DIV:  hrdata <= {9'h000, cfg_r.g4_div, cfg_r.grp_div};
                `REG_DELAY_CTRL: hrdata <= {15'h0000, cfg_r.hs, 6'h00, cfg_r.dly};
                `REG_STATUS:     hrdata <= {16'h0000, applied_dly_r, pin_f_r[4],
                                            sync_r, group4_output_a,
                                            group_clock_out[1:0]};
                default:         hrdata <= 32'h0000_0000;
            endcase
        end else begin
            hrdata <= 32'h0000_0000;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // effective settings, pins or registers
    // ---------------------------------------------------------------
    logic [2:0][3:0] grp_div_eff;
    logic [10:0]     g4_div_eff;
    logic [1:0]      in_en_eff;

    always_comb begin
        grp_div_eff = cfg_r.grp_div;
        g4_div_eff  = cfg_r.g4_div;
        in_en_eff   = cfg_r.in_en;
        if (pin_f_r[4]) begin
            in_en_eff = 2'b00;
            if (pin_f_r[3]) begin
                grp_div_eff = {3{`STRAP_HIGH_GRP_DIV}};
                g4_div_eff  = `STRAP_HIGH_G4_DIV;
            end else begin
                grp_div_eff = {3{`STRAP_LOW_GRP_DIV}};
                g4_div_eff  = `STRAP_LOW_G4_DIV;
            end
        end
    end

    // ---------------------------------------------------------------
    // input dividers and sync registration, one per bank
    // ---------------------------------------------------------------
    logic [1:0] in_prev_r;
    logic [1:0] dist_lvl_r;
    logic [1:0] dist_prev_r;
    logic [1:0] dtick;
    logic [1:0] sync_req;

    genvar b;
    generate
        for (b = 0; b < 2; b++) begin : g_bank
            logic [2:0] icnt_r;
            logic [2:0] idiv;
            assign idiv     = (cfg_r.in_div[b] < 3'h2) ? 3'h2 : cfg_r.in_div[b];
            assign dtick[b] = dist_lvl_r[b] ^ dist_prev_r[b];
            assign sync_req[b] = (pin_f_r[2] ^ cfg_r.inv) | (sw_sync_cnt_r != 6'h00);

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    in_prev_r[b]  <= 1'b0;
                    icnt_r        <= 3'h0;
                    dist_lvl_r[b] <= 1'b0;
                    dist_prev_r[b] <= 1'b0;
                end else begin
                    in_prev_r[b]   <= pin_f_r[b];
                    dist_prev_r[b] <= dist_lvl_r[b];
                    if (!in_en_eff[b]) begin
                        dist_lvl_r[b] <= pin_f_r[b];
                    end else if (pin_f_r[b] != in_prev_r[b]) begin
                        if (icnt_r >= idiv - 3'h1) begin
                            icnt_r        <= 3'h0;
                            dist_lvl_r[b] <= ~dist_lvl_r[b];
                        end else begin
                            icnt_r <= icnt_r + 3'h1;
                        end
                    end
                end
            end

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    sync_r[b] <= 1'b0;
                end else if (dtick[b] && dist_lvl_r[b]) begin
                    sync_r[b] <= sync_req[b];
                end
            end
        end
    endgenerate

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            applied_dly_r <= `RST_DLY;
        end else if (sync_r[1] && !cfg_r.excl[3]) begin
            applied_dly_r <= cfg_r.dly;
        end
    end

    // ---------------------------------------------------------------
    // output groups
    // ---------------------------------------------------------------
    logic        hs_prev_r;
    logic        hs_rose;
    logic        hs_fell;
    logic [10:0] g4_release;
    logic [3:0]  grp_out;

    assign hs_rose = cfg_r.hs & ~hs_prev_r;
    assign hs_fell = ~cfg_r.hs & hs_prev_r;

    assign g4_release = {applied_dly_r, 1'b0} - {10'h000, cfg_r.hs}
                        + ((g4_div_eff > 11'h001) ? `REL_HALF_DIVN : `REL_HALF_DIV1);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hs_prev_r <= 1'b0;
        end else begin
            hs_prev_r <= cfg_r.hs;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_grp
            localparam int BK = (g < 2) ? 0 : 1;
            grp_state_e  st_r;
            logic [10:0] cnt_r;
            logic [10:0] div;
            logic        skip_r;
            logic        adv_r;
            logic        tick;
            logic        hold;

            if (g == 3) begin : g_big
                assign div = (g4_div_eff == 11'h000) ? 11'h001 : g4_div_eff;
                assign tick = (dtick[BK] & ~skip_r) | (adv_r & ~dtick[BK]);
            end else begin : g_small
                assign div = (grp_div_eff[g] == 4'h0) ? 11'h001 : {7'h00, grp_div_eff[g]};
                assign tick = dtick[BK];
            end
            assign hold = sync_r[BK] & ~cfg_r.excl[g];

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    skip_r <= 1'b0;
                end else if (g == 3 && hs_fell && st_r == ST_RUN) begin
                    skip_r <= 1'b1;
                end else if (dtick[BK]) begin
                    skip_r <= 1'b0;
                end
            end

            // extra half tick, taken on a cycle without a distribution tick
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    adv_r <= 1'b0;
                end else if (g == 3 && hs_rose && st_r == ST_RUN) begin
                    adv_r <= 1'b1;
                end else if (!dtick[BK]) begin
                    adv_r <= 1'b0;
                end
            end

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    st_r       <= ST_RUN;
                    cnt_r      <= 11'h000;
                    grp_out[g] <= 1'b0;
                end else if (hold) begin
                    st_r       <= ST_HOLD;
                    cnt_r      <= 11'h000;
                    grp_out[g] <= 1'b0;
                end else begin
                    unique case (st_r)
                        ST_HOLD: begin
                            st_r  <= ST_WAIT;
                            cnt_r <= (g == 3) ? g4_release : `REL_HALF_DIV1;
                        end
                        ST_WAIT: begin
                            if (tick && cnt_r <= 11'h001) begin
                                st_r       <= ST_RUN;
                                cnt_r      <= 11'h000;
                                grp_out[g] <= 1'b1;
                            end else if (tick) begin
                                cnt_r <= cnt_r - 11'h001;
                            end
                        end
                        ST_RUN: begin
                            if (tick && cnt_r >= div - 11'h001) begin
                                cnt_r      <= 11'h000;
                                grp_out[g] <= ~grp_out[g];
                            end else if (tick) begin
                                cnt_r <= cnt_r + 11'h001;
                            end
                        end
                        default: begin
                            st_r <= ST_RUN;
                        end
                    endcase
                end
            end
        end
    endgenerate

    assign group_clock_out = grp_out[2:0];
    assign group4_output_a = grp_out[3];
    assign group4_output_b = grp_out[3];

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_HOLD_LOW: assert property (sync_r[1] && !cfg_r.excl[3] |=> !group4_output_a)
        else $error("group4 not held low during sync");
    AST_EXCL_KEEP: assert property (sync_r[1] && cfg_r.excl[3] |=> $stable(applied_dly_r))
        else $error("excluded group4 took a new delay");
    AST_APPLY_DLY: assert property (sync_r[1] && !cfg_r.excl[3] |=> applied_dly_r == $past(cfg_r.dly))
        else $error("delay not applied at sync");
    AST_POL_SYNC: assert property ($changed(cfg_r.inv) |-> sync_req[1])
        else $error("polarity toggle did not request sync");
    AST_SYNC_EDGE: assert property ($rose(sync_r[0]) |-> $past(dist_lvl_r[0] && sync_req[0]))
        else $error("sync registered off a distribution edge");
    AST_G4_LOAD: assert property (g_grp[3].st_r == ST_HOLD && !sync_r[1] ##1 g_grp[3].st_r == ST_WAIT
        |-> g_grp[3].cnt_r == $past(g4_release))
        else $error("group4 release count wrong");
    AST_DUTY: assert property (g_grp[3].st_r == ST_RUN && g_grp[3].cnt_r < g_grp[3].div
        |=> $changed(g_grp[3].div) || g_grp[3].cnt_r < g_grp[3].div)
        else $error("group4 divider counter out of range");
    AST_STRAP: assert property (pin_f_r[4] && !pin_f_r[3] |-> g4_div_eff == `STRAP_LOW_G4_DIV)
        else $error("strap low mapping not used");
    AST_TOGETHER: assert property (g_grp[0].st_r == ST_WAIT && g_grp[1].st_r == ST_WAIT
        && g_grp[0].cnt_r == g_grp[1].cnt_r |=> grp_out[0] == grp_out[1])
        else $error("bank a groups did not rise together");
    AST_PIN_SENSE: assert property (sw_sync_cnt_r == 6'h00 |-> sync_req[0] == (pin_f_r[2] ^ cfg_r.inv))
        else $error("sync pin sense wrong");

endmodule

// [rtl/clkdiv_regs.svh]
// register offsets, field positions, reset values and timing counts
`ifndef CLKDIV_REGS_SVH
`define CLKDIV_REGS_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define REG_INPUT_CTRL     8'h00
`define REG_GROUP_DIV      8'h04
`define REG_DELAY_CTRL     8'h08
`define REG_STATUS         8'h0C

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define F_IN_EN_A          0
`define F_IN_EN_B          1
`define F_IN_DIV_A_LO      4
`define F_IN_DIV_B_LO      8
`define F_EXCL_LO          12
`define F_POL_INV          16
`define F_G4_DIV_LO        12
`define F_DLY_LO           0
`define F_HS               16

// ---------------------------------------------------------------
// reset values: bypass everywhere, divide by one
// ---------------------------------------------------------------
`define RST_IN_DIV         3'h2
`define RST_GRP_DIV        4'h1
`define RST_G4_DIV         11'h001
`define RST_DLY            10'h005

// ---------------------------------------------------------------
// strap mappings for the configuration-select pin
// ---------------------------------------------------------------
`define STRAP_LOW_GRP_DIV  4'h1
`define STRAP_LOW_G4_DIV   11'h001
`define STRAP_HIGH_GRP_DIV 4'h2
`define STRAP_HIGH_G4_DIV  11'h002

// ---------------------------------------------------------------
// timing counts, in distribution half periods or hclk cycles
// ---------------------------------------------------------------
`define REL_HALF_DIV1      11'h00A
`define REL_HALF_DIVN      11'h00C
`define SW_SYNC_CYCLES     6'h20

`endif

// [rtl/clkdiv_pkg.sv]
// types shared by the clock divide, delay and sync block
package clkdiv_pkg;

    typedef struct packed {
        logic [1:0]       in_en;
        logic [1:0][2:0]  in_div;
        logic [2:0][3:0]  grp_div;
        logic [10:0]      g4_div;
        logic [3:0]       excl;
        logic             inv;
        logic [9:0]       dly;
        logic             hs;
    } cfg_s;

    typedef struct packed {
        logic        hsel;
        logic [7:0]  haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic        hready;
    } ahb_req_s;

    typedef enum logic [1:0] {
        ST_RUN  = 2'b00,
        ST_HOLD = 2'b01,
        ST_WAIT = 2'b10
    } grp_state_e;

endpackage

// [verif/clock_source_model.sv]
// reference clock sources for both banks
`timescale 1ns/1ps

module clock_source_model #(
    parameter int HALF = 4
) (
    // clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // source clocks
    output logic      bank_a_clk,
    output logic      bank_b_clk
);
    int cnt_r;

    // bank b stable
    // both sources run from reset release on, well before any sync
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_r      <= 0;
            bank_a_clk <= 1'b0;
            bank_b_clk <= 1'b0;
        end else if (cnt_r == HALF - 1) begin
            cnt_r      <= 0;
            bank_a_clk <= ~bank_a_clk;
            bank_b_clk <= ~bank_b_clk;
        end else begin
            cnt_r <= cnt_r + 1;
        end
    end
endmodule

// [verif/testbench.sv]
// self-checking bench for the clock divide, delay and sync block
`timescale 1ns/1ps
`include "clkdiv_regs.svh"

module testbench;
    import clkdiv_pkg::*;

    localparam int HALF = 4;

    logic        hclk;
    logic        hresetn;
    ahb_req_s    req;
    ahb_req_s    bus;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        bank_a;
    logic        bank_b;
    logic        sync_pin;
    logic        sel_level;
    logic        sel_driven;
    logic [2:0]  grp_out;
    logic        g4_a;
    logic        g4_b;
    logic [3:0]  outs;
    int          err_count;
    int          checks_done;
    int          cyc;

    always_comb begin
        bus        = req;
        bus.hready = hreadyout;
    end
    assign outs = {g4_a, grp_out};

    clock_source_model #(.HALF(HALF)) u_src (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .bank_a_clk (bank_a),
        .bank_b_clk (bank_b)
    );

    clock_divide_delay_sync u_dut (
        .hclk               (hclk),
        .hresetn            (hresetn),
        .ahb_req            (bus),
        .hwdata             (hwdata),
        .hrdata             (hrdata),
        .hreadyout          (hreadyout),
        .hresp              (hresp),
        .bank_a_clock_input (bank_a),
        .bank_b_clock_input (bank_b),
        .sync_pin           (sync_pin),
        .cfg_sel_level      (sel_level),
        .cfg_sel_driven     (sel_driven),
        .group_clock_out    (grp_out),
        .group4_output_a    (g4_a),
        .group4_output_b    (g4_b)
    );

    initial hclk = 1'b0;
    always #2 hclk = ~hclk;
    always @(posedge hclk) cyc <= cyc + 1;

    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task automatic end_of_test();
        if (err_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge hclk);
        req.hsel   <= 1'b1;
        req.haddr  <= a;
        req.htrans <= 2'h2;
        req.hwrite <= wr;
        req.hsize  <= 3'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        req.hsel   <= 1'b0;
        req.htrans <= 2'h0;
        hwdata     <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        q = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        xfer(1'b0, a, 32'h0, q);
    endtask

    task automatic wait_edge(input int i, input logic lvl, output int t);
        while (outs[i] === lvl) @(posedge hclk);
        while (outs[i] !== lvl) @(posedge hclk);
        t = cyc;
    endtask

    task automatic duty(input int i, input int half);
        int t0;
        int t1;
        int t2;
        wait_edge(i, 1'b1, t0);
        wait_edge(i, 1'b0, t1);
        wait_edge(i, 1'b1, t2);
        check(t1 - t0, half);
        check(t2 - t1, half);
    endtask

    task automatic rises(output int t[4]);
        logic [3:0] prev;
        prev = outs;
        t = '{-1, -1, -1, -1};
        repeat (5000) begin
            @(posedge hclk);
            for (int i = 0; i < 4; i++) begin
                if (outs[i] && !prev[i] && t[i] < 0) t[i] = cyc;
            end
            prev = outs;
            if (t[0] >= 0 && t[1] >= 0 && t[2] >= 0 && t[3] >= 0) break;
        end
        check(32'(g4_b), 32'(g4_a));
    endtask

    task automatic hold_check(input logic [3:0] exp);
        logic [3:0] seen;
        seen = 4'h0;
        repeat (24) @(posedge hclk);
        repeat (40) begin
            @(posedge hclk);
            seen = seen | outs;
        end
        check(32'(seen), 32'(exp));
    endtask

    task automatic pulse_sync();
        sync_pin <= 1'b1;
        repeat (80) @(posedge hclk);
        sync_pin <= 1'b0;
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic reg_case();
        logic [31:0] q;
        rd(`REG_INPUT_CTRL, q);
        check(q, 32'h0000_0220);
        rd(`REG_GROUP_DIV, q);
        check(q, 32'h0000_1111);
        rd(`REG_DELAY_CTRL, q);
        check(q, 32'h0000_0005);
        wr(8'h40, 32'hFFFF_FFFF);
        rd(8'h40, q);
        check(q, 32'h0);
        wr(`REG_STATUS, 32'hFFFF_FFFF);
        rd(`REG_STATUS, q);
        check(32'(q[15:6]), 32'h5);
        check(32'(hresp), 32'h0);
    endtask

    task automatic sync_case(input int dly, input logic hs, input int div4);
        logic [31:0] q;
        int          t[4];
        wr(`REG_GROUP_DIV, 32'h0000_0111 | 32'(div4 << 12));
        wr(`REG_DELAY_CTRL, {15'h0, hs, 6'h0, dly[9:0]});
        sync_pin <= 1'b1;
        hold_check(4'h0);
        rd(`REG_STATUS, q);
        check(32'(q[15:6]), dly);
        sync_pin <= 1'b0;
        rises(t);
        check(t[1] - t[0], 0);
        check(t[2] - t[0], 0);
        check(t[3] - t[2], (2 * dly - int'(hs) + (div4 > 1 ? 2 : 0)) * HALF);
    endtask

    task automatic half_step_case();
        int t[4];
        wr(`REG_DELAY_CTRL, 32'h0001_0007);
        repeat (16) @(posedge hclk);
        rises(t);
        check(32'((t[3] - t[2]) & 7), 32'h4);
    endtask

    task automatic excl_case();
        logic [31:0] q;
        wr(`REG_INPUT_CTRL, 32'h0000_8220);
        wr(`REG_DELAY_CTRL, 32'h0000_0009);
        sync_pin <= 1'b1;
        hold_check(4'h8);
        rd(`REG_STATUS, q);
        check(32'(q[15:6]), 32'h7);
        sync_pin <= 1'b0;
        wr(`REG_INPUT_CTRL, 32'h0000_0220);
    endtask

    task automatic pol_case();
        int t[4];
        int c0;
        wr(`REG_INPUT_CTRL, 32'h0001_0220);
        hold_check(4'h0);
        sync_pin <= 1'b1;
        rises(t);
        check(t[3] - t[2], 18 * HALF);
        sync_pin <= 1'b0;
        repeat (20) @(posedge hclk);
        wr(`REG_INPUT_CTRL, 32'h0000_0220);
        c0 = cyc;
        rises(t);
        check(32'(t[2] - c0 > 66), 32'h1);
    endtask

    task automatic div_case();
        wr(`REG_INPUT_CTRL, 32'h0000_0231);
        wr(`REG_GROUP_DIV, 32'h0041_5851);
        pulse_sync();
        duty(0, 3 * HALF);
        duty(1, 15 * HALF);
        duty(2, 8 * HALF);
        duty(3, 1045 * HALF);
        wr(`REG_INPUT_CTRL, 32'h0000_0722);
        pulse_sync();
        duty(2, 56 * HALF);
    endtask

    task automatic strap_case(input logic lvl, input int half);
        sel_driven <= 1'b1;
        sel_level  <= lvl;
        pulse_sync();
        duty(0, half);
        duty(3, half);
    endtask

    // ---------------------------------------------------------------
    // main sequence and watchdog
    // ---------------------------------------------------------------
    initial begin
        hresetn     = 1'b0;
        req         = '0;
        hwdata      = 32'h0;
        sync_pin    = 1'b0;
        sel_level   = 1'b0;
        sel_driven  = 1'b0;
        err_count   = 0;
        checks_done = 0;
        cyc         = 0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        reg_case();
        sync_case(522, 1'b0, 2);
        sync_case(5, 1'b1, 1);
        sync_case(7, 1'b0, 1);
        half_step_case();
        excl_case();
        pol_case();
        div_case();
        strap_case(1'b0, HALF);
        strap_case(1'b1, 2 * HALF);
        end_of_test();
    end

    initial begin
        repeat (100000) @(posedge hclk);
        err_count++;
        end_of_test();
    end
endmodule
